//--- core/ees_pkg.sv
// Shared constants and types for the serial SRAM front end
package ees_pkg;

  // Opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_WRITE  = 8'h02;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_STORE  = 8'h08;
  localparam logic [7:0] OP_RECALL = 8'h09;
  localparam logic [7:0] OP_USR_WR = 8'hC2;
  localparam logic [7:0] OP_USR_RD = 8'hC3;

  // Status register layout
  localparam logic [7:0] SR_WR_MASK  = 8'hEC;
  localparam logic [7:0] SR_RESET    = 8'h00;
  localparam int         SR_WEL_BIT  = 1;
  localparam int         SR_PAGE_BIT = 5;

  // Array and user space geometry
  localparam int         ADDR_W    = 13;
  localparam int         MEM_DEPTH = 8192;
  localparam int         PAGE_W    = 5;
  localparam int         USR_W     = 16;
  localparam logic [USR_W-1:0] USR_RESET = 16'h0000;

  // Sequencing counts
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] BIT_FIRST  = 3'h0;
  localparam logic [1:0] ADDR_LAST  = 2'h1;
  localparam logic [1:0] USR_FULL   = 2'h2;
  localparam logic [1:0] BYTE_SAT   = 2'h3;
  localparam logic [1:0] SETTLE_CYC = 2'h2;

  // Pins sampled from the link, in one bundle
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic pwr_fail;
  } ees_pins_t;

  localparam ees_pins_t PIN_IDLE = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, hold_n: 1'h1, pwr_fail: 1'h0};

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_OPCODE = 10'h002,
    ST_ADDR   = 10'h004,
    ST_WDATA  = 10'h008,
    ST_RDATA  = 10'h010,
    ST_SR_W   = 10'h020,
    ST_SR_R   = 10'h040,
    ST_USR_W  = 10'h080,
    ST_USR_R  = 10'h100,
    ST_IGNORE = 10'h200
  } ees_state_t;

endpackage : ees_pkg

//--- core/ees_sync.sv
// Two-stage synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none
module ees_sync (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Raw pins and their synchronised copy
  input  wire ees_pkg::ees_pins_t pin_raw,
  output var  ees_pkg::ees_pins_t pin_sync
);
  import ees_pkg::*;

  localparam int W = $bits(ees_pins_t);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          meta_reg[gi] <= PIN_IDLE[gi];
          sync_reg[gi] <= PIN_IDLE[gi];
        end else begin
          meta_reg[gi] <= pin_raw[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign pin_sync = ees_pins_t'(sync_reg);

endmodule : ees_sync
`default_nettype wire

//--- core/ees_user_space.sv
// Two-byte user storage with its backup copy
`timescale 1ns/1ps
`default_nettype none
module ees_user_space (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Whole-word write
  input  wire logic                      commit,
  input  wire logic [ees_pkg::USR_W-1:0] wdata,
  // Backup control
  input  wire logic                      store,
  input  wire logic                      recall,
  // Current value
  output var  logic [ees_pkg::USR_W-1:0] value
);
  import ees_pkg::*;

  logic [USR_W-1:0] value_reg;
  logic [USR_W-1:0] backup_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      value_reg <= USR_RESET;
    end else if (commit) begin
      value_reg <= wdata;
    end else if (recall) begin
      value_reg <= backup_reg;
    end
  end

  // Backup is modelled as a register; reset stands in for a blank backup
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      backup_reg <= USR_RESET;
    end else if (store) begin
      backup_reg <= value_reg;
    end
  end

  assign value = value_reg;

  AST_USR_COMMIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    commit |=> value_reg == $past(wdata))
    else $error("user space did not take the full word");

  AST_USR_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    store && !commit && !recall |=> backup_reg == value_reg)
    else $error("user space backup missed a store");

endmodule : ees_user_space
`default_nettype wire

//--- core/ees_spi_front.sv
// Serial slave front end of the 64-Kbit SPI SRAM with shadow backup
// Functional notes
// - Deselected means standby and output high impedance
// - Deselected device ignores the serial input
// - Rising select completes a valid write
// - No decoding before first select falling edge
// - Sample on rising clock, shift on falling
// - All bytes travel most significant bit first
// - First bit taken at first rise after select
// - Clock modes 0 and 3 both work
// - Pause starts only while clock is low
// - Resume takes effect only while clock is low
// - Paused device ignores clock and input, keeps state
// - Output floats at once while pause low
// - Continuous or 32-byte page addressing by mode bit
// - Two-byte user space, no address bytes
// - User space write needs all 16 bits
// - User space read may stop early
// - User space backed up with array and status; the code backs up only user space and status, the array has no backup
// - Status has writable and read-only bits, recallable
// - First byte after select is the opcode
// - Select rising during pause aborts, clears enable latch
// - User write opcode C2h, two data bytes
`timescale 1ns/1ps
`default_nettype none
module ees_spi_front (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Serial link pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  output var  logic so,
  output var  logic so_oe_n,
  // Backup control
  input  wire logic pwr_fail,
  output var  logic standby,
  output var  logic store_pulse,
  output var  logic recall_pulse
);
  import ees_pkg::*;

  ees_pins_t        pin_raw;
  ees_pins_t        pin_s;
  logic             cs_s;
  logic             sck_s;
  logic             si_s;
  logic             hold_s;
  logic             pf_s;
  logic             cs_prev_reg;
  logic             sck_prev_reg;
  logic             pf_prev_reg;
  logic             cs_fall;
  logic             cs_rise;
  logic             sck_rise;
  logic             sck_fall;
  logic             pf_rise;
  logic [1:0]       settle_reg;
  logic             armed_reg;
  logic             paused_reg;
  logic             active;
  logic             rx_edge;
  logic             tx_edge;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       rx_next;
  logic             byte_done;
  logic [1:0]       byte_cnt_reg;
  ees_state_t       state_reg;
  ees_state_t       state_next;
  logic             wr_op_reg;
  logic             op_done;
  logic             abort;
  logic             commit_rise;
  logic             rd_state;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_inc;
  logic [7:0]       mem [MEM_DEPTH];
  logic             pend_valid_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [7:0]       pend_data_reg;
  logic             mem_we;
  logic             wd_byte;
  logic             wel_reg;
  logic [7:0]       sr_reg;
  logic [7:0]       sr_backup_reg;
  logic [7:0]       sr_pend_reg;
  logic             sr_pend_valid_reg;
  logic [7:0]       sr_read;
  logic [USR_W-1:0] usr_buf_reg;
  logic [USR_W-1:0] usr_val;
  logic             usr_idx_reg;
  logic             usr_commit;
  logic             store_now;
  logic             recall_now;
  logic [7:0]       tx_src;
  logic [7:0]       tx_reg;
  logic             so_reg;
  logic             so_oe_n_reg;
  logic             standby_reg;
  logic             store_reg;
  logic             recall_reg;

  assign pin_raw = {cs_n, sck, si, hold_n, pwr_fail};

  ees_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_raw  (pin_raw),
    .pin_sync (pin_s)
  );

  assign cs_s   = pin_s.cs_n;
  assign sck_s  = pin_s.sck;
  assign si_s   = pin_s.si;
  assign hold_s = pin_s.hold_n;
  assign pf_s   = pin_s.pwr_fail;

  // Edges are found on the synchronised copies; idle level of the clock does not matter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_prev_reg  <= PIN_IDLE.cs_n;
      sck_prev_reg <= PIN_IDLE.sck;
      pf_prev_reg  <= PIN_IDLE.pwr_fail;
    end else begin
      cs_prev_reg  <= cs_s;
      sck_prev_reg <= sck_s;
      pf_prev_reg  <= pf_s;
    end
  end

  assign cs_fall  = !cs_s && cs_prev_reg;
  assign cs_rise  = cs_s && !cs_prev_reg;
  assign sck_rise = sck_s && !sck_prev_reg;
  assign sck_fall = !sck_s && sck_prev_reg;
  assign pf_rise  = pf_s && !pf_prev_reg;

  // The synchroniser shows its reset level for a while, so arming waits for it to settle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      settle_reg <= 2'h0;
      armed_reg  <= 1'h0;
    end else if (settle_reg != SETTLE_CYC) begin
      settle_reg <= settle_reg + 2'h1;
    end else if (cs_s) begin
      armed_reg <= 1'h1;
    end
  end

  // Pause follows the pause pin only while the clock is low; deselect clears it at any clock level
  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_s) begin
      paused_reg <= 1'h0;
    end else if (!sck_s) begin
      paused_reg <= !hold_s;
    end
  end

  assign active    = !cs_s && !paused_reg && (state_reg != ST_IDLE);
  assign rx_edge   = active && sck_rise;
  assign tx_edge   = active && sck_fall;
  assign rx_next   = {rx_reg[6:0], si_s};
  assign byte_done = rx_edge && (bit_cnt_reg == BIT_LAST);
  assign op_done   = byte_done && (state_reg == ST_OPCODE);
  assign abort       = cs_rise && !hold_s;
  assign commit_rise = cs_rise && hold_s;
  assign rd_state  = (state_reg == ST_RDATA) || (state_reg == ST_SR_R) || (state_reg == ST_USR_R);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_s) begin
      bit_cnt_reg <= BIT_FIRST;
      rx_reg      <= 8'h00;
    end else if (rx_edge) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= rx_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_s || (state_next != state_reg)) begin
      byte_cnt_reg <= 2'h0;
    end else if (byte_done && (byte_cnt_reg != BYTE_SAT)) begin
      byte_cnt_reg <= byte_cnt_reg + 2'h1;
    end
  end

  function automatic ees_state_t op_state(input logic [7:0] op, input logic write_enable_latch_bit);
    case (op)
      OP_WRITE:  op_state = write_enable_latch_bit ? ST_ADDR : ST_IGNORE;
      OP_READ:   op_state = ST_ADDR;
      OP_WRSR:   op_state = write_enable_latch_bit ? ST_SR_W : ST_IGNORE;
      OP_RDSR:   op_state = ST_SR_R;
      OP_USR_WR: op_state = ST_USR_W;
      OP_USR_RD: op_state = ST_USR_R;
      default:   op_state = ST_IGNORE;
    endcase
  endfunction : op_state

  always_comb begin
    state_next = state_reg;
    if (cs_s) begin
      state_next = ST_IDLE;
    end else if (state_reg == ST_IDLE) begin
      if (cs_fall && armed_reg) begin
        state_next = ST_OPCODE;
      end
    end else if (byte_done) begin
      unique case (state_reg)
        ST_OPCODE: state_next = op_state(rx_next, wel_reg);
        ST_ADDR: begin
          if (byte_cnt_reg == ADDR_LAST) begin
            state_next = wr_op_reg ? ST_WDATA : ST_RDATA;
          end
        end
        ST_SR_W:   state_next = ST_IGNORE;
        ST_IDLE, ST_WDATA, ST_RDATA, ST_SR_R, ST_USR_W, ST_USR_R, ST_IGNORE: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wr_op_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      if (op_done) begin
        wr_op_reg <= (rx_next == OP_WRITE);
      end
    end
  end

  // Page mode wraps inside the 32-byte page, otherwise the whole array wraps
  always_comb begin
    addr_inc = addr_reg + 13'h0001;
    if (sr_reg[SR_PAGE_BIT]) begin
      addr_inc = {addr_reg[ADDR_W-1:PAGE_W], addr_reg[PAGE_W-1:0] + 5'h01};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_reg <= '0;
    end else if (rx_edge && (state_reg == ST_ADDR)) begin
      addr_reg <= {addr_reg[ADDR_W-2:0], si_s};
    end else if (byte_done && ((state_reg == ST_WDATA) || (state_reg == ST_RDATA))) begin
      addr_reg <= addr_inc;
    end
  end

  // Each byte waits one byte or the select rise before it lands, so an abort can drop it
  assign wd_byte = byte_done && (state_reg == ST_WDATA);
  assign mem_we  = pend_valid_reg && (wd_byte || commit_rise);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_rise) begin
      pend_valid_reg <= 1'h0;
      pend_addr_reg  <= '0;
      pend_data_reg  <= 8'h00;
    end else if (wd_byte) begin
      pend_valid_reg <= 1'h1;
      pend_addr_reg  <= addr_reg;
      pend_data_reg  <= rx_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[pend_addr_reg] <= pend_data_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wel_reg <= 1'h0;
    end else if (abort) begin
      wel_reg <= 1'h0;
    end else if (commit_rise && (pend_valid_reg || sr_pend_valid_reg)) begin
      wel_reg <= 1'h0;
    end else if (op_done && (rx_next == OP_WREN)) begin
      wel_reg <= 1'h1;
    end else if (op_done && (rx_next == OP_WRDI)) begin
      wel_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_rise) begin
      sr_pend_valid_reg <= 1'h0;
      sr_pend_reg       <= 8'h00;
    end else if (byte_done && (state_reg == ST_SR_W)) begin
      sr_pend_valid_reg <= 1'h1;
      sr_pend_reg       <= rx_next;
    end
  end

  assign store_now  = (op_done && (rx_next == OP_STORE)) || pf_rise;
  assign recall_now = op_done && (rx_next == OP_RECALL);

  // Only the writable bits are held; read-only bits are rebuilt on every read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sr_reg <= SR_RESET;
    end else if (recall_now) begin
      sr_reg <= sr_backup_reg & SR_WR_MASK;
    end else if (commit_rise && sr_pend_valid_reg) begin
      sr_reg <= sr_pend_reg & SR_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sr_backup_reg <= SR_RESET;
    end else if (store_now) begin
      sr_backup_reg <= sr_reg;
    end
  end

  always_comb begin
    sr_read             = sr_reg & SR_WR_MASK;
    sr_read[SR_WEL_BIT] = wel_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_s) begin
      usr_buf_reg <= USR_RESET;
    end else if (rx_edge && (state_reg == ST_USR_W)) begin
      usr_buf_reg <= {usr_buf_reg[USR_W-2:0], si_s};
    end
  end

  // Exactly sixteen bits and a clean select rise, else the old value stays
  assign usr_commit = commit_rise && (state_reg == ST_USR_W) && (byte_cnt_reg == USR_FULL)
                      && (bit_cnt_reg == BIT_FIRST);

  ees_user_space u_usr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .commit  (usr_commit),
    .wdata   (usr_buf_reg),
    .store   (store_now),
    .recall  (recall_now),
    .value   (usr_val)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_s) begin
      usr_idx_reg <= 1'h0;
    end else if (byte_done && (state_reg == ST_USR_R)) begin
      usr_idx_reg <= !usr_idx_reg;
    end
  end

  always_comb begin
    if (state_reg == ST_RDATA) begin
      tx_src = mem[addr_reg];
    end else if (state_reg == ST_SR_R) begin
      tx_src = sr_read;
    end else begin
      tx_src = usr_idx_reg ? usr_val[7:0] : usr_val[15:8];
    end
  end

  // A fresh byte is taken at the first fall of each byte, so the address is already current
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_reg <= 1'h0;
      tx_reg <= 8'h00;
    end else if (tx_edge && rd_state) begin
      if (bit_cnt_reg == BIT_FIRST) begin
        so_reg <= tx_src[7];
        tx_reg <= {tx_src[6:0], 1'h0};
      end else begin
        so_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'h0};
      end
    end
  end

  // Enable follows the pause pin itself, not the clock-gated pause state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_oe_n_reg <= 1'h1;
      standby_reg <= 1'h1;
      store_reg   <= 1'h0;
      recall_reg  <= 1'h0;
    end else begin
      so_oe_n_reg <= !(!cs_s && hold_s && rd_state);
      standby_reg <= cs_s;
      store_reg   <= store_now;
      recall_reg  <= recall_now;
    end
  end

  assign so           = so_reg;
  assign so_oe_n      = so_oe_n_reg;
  assign standby      = standby_reg;
  assign store_pulse  = store_reg;
  assign recall_pulse = recall_reg;

  sequence s_pause_req;
    !cs_s && !hold_s && !sck_s;
  endsequence

  sequence s_pause_late;
    !cs_s && !hold_s && sck_s && !paused_reg;
  endsequence

  sequence s_abort_rise;
    cs_rise && !hold_s;
  endsequence

  AST_DESEL_HIZ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_s |=> so_oe_n_reg && standby_reg)
    else $error("output driven while deselected");

  AST_DESEL_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_s |=> (state_reg == ST_IDLE) && (bit_cnt_reg == BIT_FIRST))
    else $error("deselected device accepted bits");

  AST_WRITE_DONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    commit_rise && pend_valid_reg |=> mem[$past(pend_addr_reg)] == $past(pend_data_reg))
    else $error("write not completed on select rise");

  AST_NO_EARLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !armed_reg |=> state_reg == ST_IDLE)
    else $error("decoding started before first select fall");

  AST_SO_ON_FALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(so_reg) |-> $past(sck_fall) && $past(rd_state))
    else $error("output changed away from a falling clock");

  AST_MSB_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_edge |=> rx_reg == {$past(rx_reg[6:0]), $past(si_s)})
    else $error("input not shifted in msb first");

  AST_BIT_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_edge && !cs_s |=> bit_cnt_reg == 3'($past(bit_cnt_reg) + 3'h1))
    else $error("rising edge did not take one bit");

  AST_PAUSE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pause_req |=> paused_reg)
    else $error("pause not entered with clock low");

  AST_PAUSE_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pause_late |=> !paused_reg)
    else $error("pause entered while clock high");

  AST_RESUME_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hold_s && !sck_s |=> !paused_reg)
    else $error("resume not taken with clock low");

  AST_PAUSE_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    paused_reg && !cs_s |=> $stable(bit_cnt_reg) && $stable(state_reg) && $stable(so_reg))
    else $error("sequence moved while paused");

  AST_HOLD_HIZ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !hold_s |=> so_oe_n_reg)
    else $error("output driven while pause pin low");

  AST_PAGE_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    byte_done && (state_reg == ST_RDATA) && sr_reg[SR_PAGE_BIT] |=> $stable(addr_reg[ADDR_W-1:PAGE_W]))
    else $error("page mode address left its page");

  AST_USR_ABORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_rise && (state_reg == ST_USR_W) && (byte_cnt_reg != USR_FULL) |=> $stable(usr_val))
    else $error("partial user write changed the value");

  AST_HOLD_ABORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_abort_rise |=> !wel_reg && !pend_valid_reg && $stable(sr_reg))
    else $error("abort under pause did not clear state");

endmodule : ees_spi_front
`default_nettype wire

//--- test/ees_master_model.sv
// Behavioural SPI master that drives the front end's link pins
`timescale 1ns/1ps
`default_nettype none
module ees_master_model (
  // Clock
  input  wire logic clk_sys,
  // Link pins
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic hold_n,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic       mode3   = 1'b0;
  logic [7:0] rx;
  logic       oe_held;
  logic       oe_back;
  int         hold_at = -1;
  event       got;

  initial {cs_n, sck, si, hold_n} = 4'h9;

  // Released data line never shows a steady value
  always @(posedge clk_sys) if (cs_n) si <= ~si;

  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w

  task automatic mode(input logic v);
    w(1);
    mode3 = v;
    sck <= v;
    w(8);
  endtask : mode

  task automatic sel();
    w(1);
    cs_n <= 1'b0;
    w(5);
  endtask : sel

  task automatic desel();
    w(1);
    sck <= mode3;
    w(4);
    cs_n <= 1'b1;
    w(5);
  endtask : desel

  // Stray clock edges while paused would shift a bit if not ignored
  task automatic pause(input logic bi);
    hold_n <= 1'b0;
    w(4);
    sck <= 1'b1;
    si  <= ~bi;
    w(4);
    oe_held = so_oe_n;
    // Released with the clock high, so the resume must wait for the next fall
    hold_n <= 1'b1;
    w(4);
    oe_back = so_oe_n;
    sck <= 1'b0;
    si  <= bi;
    w(4);
  endtask : pause

  task automatic xfer(input logic [7:0] b, input bit lsn);
    for (int i = 7; i >= 0; i--) begin
      w(1);
      sck <= 1'b0;
      si  <= b[i];
      w(4);
      if (7 - i == hold_at) pause(b[i]);
      sck <= 1'b1;
      w(3);
      // An undriven output reads as the inverse of its last value
      rx[i] = so_oe_n ? ~so : so;
    end
    if (lsn) ->got;
  endtask : xfer

  // Deselect with the pause pin low, on purpose
  task automatic abort();
    w(1);
    sck <= 1'b1;
    w(4);
    // Pause asked with the clock high, so it stays pending until select rises
    hold_n <= 1'b0;
    w(4);
    cs_n <= 1'b1;
    w(4);
    hold_n <= 1'b1;
    sck    <= mode3;
    w(5);
  endtask : abort
endmodule : ees_master_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the serial SRAM front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module testbench;
  import ees_pkg::*;
  logic        clk_sys, rst_n, pwr_fail;
  logic        cs_n, sck, si, hold_n, so, so_oe_n, standby, store_pulse, recall_pulse;
  int          err_count, checked, cyc, n_store, n_recall;
  logic [7:0]  exp_q[$];
  logic [7:0]  e;
  logic [15:0] addr, d, uw;

  ees_spi_front dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n), .pwr_fail(pwr_fail), .standby(standby),
    .store_pulse(store_pulse), .recall_pulse(recall_pulse));
  ees_master_model m (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so), .so_oe_n(so_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Hang guard well above the expected few thousand cycles
  always @(posedge clk_sys) begin
    n_store  += int'(store_pulse === 1'b1);
    n_recall += int'(recall_pulse === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial forever begin
    @(m.got);
    e = exp_q.pop_front();
    `CHK("so_byte", e, m.rx)
  end

  task automatic frame(input logic [7:0] op, input logic [31:0] tx, input int ntx,
                       input logic [31:0] ex, input int nrx);
    m.sel();
    m.xfer(op, 1'b0);
    for (int k = ntx - 1; k >= 0; k--) m.xfer(tx[8*k+:8], 1'b0);
    for (int k = nrx - 1; k >= 0; k--) begin
      exp_q.push_back(ex[8*k+:8]);
      m.xfer(8'($urandom), 1'b1);
    end
    m.desel();
  endtask : frame

  initial begin
    rst_n    = 1'b0;
    pwr_fail = 1'b0;
    void'($urandom(32'h948EFF13));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    m.w(8);
    `CHK("standby", 1'b1, standby)
    `CHK("so_oe_n", 1'b1, so_oe_n)
    for (int md = 0; md < 2; md++) begin
      m.mode(md[0]);
      addr = {3'h0, 13'($urandom)};
      d    = 16'($urandom);
      frame(OP_WREN, 0, 0, 0, 0);
      frame(OP_WRITE, {addr, d}, 4, 0, 0);
      frame(OP_WRITE, {addr, ~d}, 4, 0, 0);
      m.hold_at = 3;
      frame(OP_READ, addr, 2, d, 2);
      m.hold_at = -1;
      `CHK("oe_in_pause", 1'b1, m.oe_held)
      `CHK("oe_resume", 1'b0, m.oe_back)
    end
    m.mode(1'b0);
    m.sel();
    `CHK("standby", 1'b0, standby)
    m.desel();
    uw = 16'($urandom);
    frame(OP_USR_WR, uw, 2, 0, 0);
    frame(OP_USR_RD, 0, 0, uw, 2);
    frame(OP_USR_WR, ~uw, 1, 0, 0);
    frame(OP_USR_RD, 0, 0, uw[15:8], 1);
    frame(OP_USR_RD, 0, 0, uw, 2);
    frame(OP_STORE, 0, 0, 0, 0);
    `CHK("store_count", 1, n_store)
    frame(OP_USR_WR, ~uw, 2, 0, 0);
    frame(OP_RECALL, 0, 0, 0, 0);
    `CHK("recall_count", 1, n_recall)
    frame(OP_USR_RD, 0, 0, uw, 2);
    pwr_fail <= 1'b1;
    m.w(8);
    pwr_fail <= 1'b0;
    m.w(4);
    `CHK("store_count", 2, n_store)
    frame(OP_WREN, 0, 0, 0, 0);
    frame(OP_RDSR, 0, 0, 8'h02, 1);
    m.sel();
    m.xfer(OP_READ, 1'b0);
    m.abort();
    frame(OP_RDSR, 0, 0, 8'h00, 1);
    frame(OP_WREN, 0, 0, 0, 0);
    frame(OP_WRSR, 8'hFF, 1, 0, 0);
    frame(OP_RDSR, 0, 0, SR_WR_MASK, 1);
    addr = {3'h0, 8'($urandom), 5'h1F};
    frame(OP_WREN, 0, 0, 0, 0);
    frame(OP_WRITE, {addr, d}, 4, 0, 0);
    frame(OP_READ, {addr[15:5], 5'h00}, 2, d[7:0], 1);
    frame(OP_RECALL, 0, 0, 0, 0);
    frame(OP_RDSR, 0, 0, 8'h00, 1);
    m.w(10);
    close_out();
  end
endmodule : testbench
`default_nettype wire
